// ### verilog/serial_byte_master.sv
`timescale 1ns/1ns
`default_nettype none

module serial_byte_master (
    // Clock and global reset
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    // Register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Serial clock pin
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    // Serial data pin
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o
);

    // ************************************************************
    // State
    // ************************************************************
    serial_byte_pkg::seq_state_t state_ff, nxt_state;
    logic [7:0] xfer_byte_ff,   nxt_xfer_byte;
    logic [7:0] byte_offset_ff, nxt_byte_offset;
    logic [7:0] target_addr_ff, nxt_target_addr;
    logic       short_ff,       nxt_short;
    logic       fast_ff,        nxt_fast;
    logic       err_ff,         nxt_err;
    logic [7:0] rdata_ff,       nxt_rdata;
    logic [7:0] shift_ff,       nxt_shift;
    logic [3:0] bit_ff,         nxt_bit;
    logic [1:0] ph_ff,          nxt_ph;
    logic [1:0] step_ff,        nxt_step;
    logic       rep_ff,         nxt_rep;
    logic       nack_ff,        nxt_nack;
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic       tick;
    logic       adv;
    logic       busy;
    logic       dir;
    logic       scl_low;
    logic       sda_low;

    // Pins come from another domain: two flops before use
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
        end
    end

    quarter_tick_div u_div (
        .ref_clk_i         (ref_clk_i),
        .reset_n_i         (reset_n_i),
        .fast_clock_test_i (fast_ff),
        .tick_o            (tick)
    );

    assign busy = (state_ff != serial_byte_pkg::ST_IDLE);
    assign dir  = target_addr_ff[0];
    // Hold the high phase while a target stretches the clock
    assign adv  = tick && busy && !(ph_ff == 2'h1 && !scl_sync_ff[1]);

    function automatic logic [7:0] frame_byte(input logic [1:0] step);
        logic [7:0] b;
        b = serial_byte_pkg::REG_RESET_VAL;
        if (step == serial_byte_pkg::STEP_ADDR) begin
            b = {target_addr_ff[7:1], short_ff & dir};
        end else if (step == serial_byte_pkg::STEP_INDEX) begin
            b = byte_offset_ff;
        end else begin
            b = dir ? {target_addr_ff[7:1], 1'b1} : xfer_byte_ff;
        end
        return b;
    endfunction : frame_byte

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        nxt_state       = state_ff;
        nxt_xfer_byte   = xfer_byte_ff;
        nxt_byte_offset = byte_offset_ff;
        nxt_target_addr = target_addr_ff;
        nxt_short       = short_ff;
        nxt_fast        = fast_ff;
        nxt_err         = err_ff;
        nxt_rdata       = rdata_ff;
        nxt_shift       = shift_ff;
        nxt_bit         = bit_ff;
        nxt_ph          = ph_ff;
        nxt_step        = step_ff;
        nxt_rep         = rep_ff;
        nxt_nack        = nack_ff;

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                serial_byte_pkg::XFER_BYTE_OFS:   nxt_xfer_byte   = reg_wdata_i;
                serial_byte_pkg::BYTE_OFFSET_OFS: nxt_byte_offset = reg_wdata_i;
                serial_byte_pkg::TARGET_ADDR_OFS: begin
                    nxt_target_addr = reg_wdata_i;
                    if (!busy) begin
                        nxt_state = serial_byte_pkg::ST_START;
                        nxt_rep   = 1'b0;
                        nxt_ph    = 2'h0;
                        nxt_step  = serial_byte_pkg::STEP_ADDR;
                    end
                end
                serial_byte_pkg::CTRL_STATUS_OFS: begin
                    nxt_short = reg_wdata_i[serial_byte_pkg::SHORT_FRAME_BIT];
                    nxt_fast  = reg_wdata_i[serial_byte_pkg::FAST_TEST_BIT];
                    if (reg_wdata_i[serial_byte_pkg::REQ_ERR_BIT]) begin
                        nxt_err = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        if (reg_rd_i) begin
            unique case (reg_addr_i)
                serial_byte_pkg::XFER_BYTE_OFS:   nxt_rdata = xfer_byte_ff;
                serial_byte_pkg::BYTE_OFFSET_OFS: nxt_rdata = byte_offset_ff;
                serial_byte_pkg::TARGET_ADDR_OFS: nxt_rdata = target_addr_ff;
                serial_byte_pkg::CTRL_STATUS_OFS:
                    nxt_rdata = {short_ff, 1'b0, busy, 2'b00, fast_ff, err_ff, 1'b0};
                default:                          nxt_rdata = serial_byte_pkg::REG_RESET_VAL;
            endcase
        end

        if (adv) begin
            nxt_ph = ph_ff + 2'h1;
            if (ph_ff == 2'h2 && bit_ff != serial_byte_pkg::ACK_BIT_NUM) begin
                nxt_shift = (state_ff == serial_byte_pkg::ST_RECV) ? {shift_ff[6:0], sda_sync_ff[1]}
                                                                  : shift_ff;
            end
            if (ph_ff == 2'h2 && bit_ff == serial_byte_pkg::ACK_BIT_NUM) begin
                nxt_nack = sda_sync_ff[1];
            end
            if (ph_ff == 2'h3) begin
                unique case (state_ff)
                    serial_byte_pkg::ST_START: begin
                        nxt_state = serial_byte_pkg::ST_SEND;
                        nxt_shift = frame_byte(step_ff);
                        nxt_bit   = 4'h0;
                    end
                    serial_byte_pkg::ST_SEND: begin
                        if (bit_ff != serial_byte_pkg::ACK_BIT_NUM) begin
                            nxt_bit   = bit_ff + 4'h1;
                            nxt_shift = {shift_ff[6:0], 1'b0};
                        end else if (nack_ff) begin
                            nxt_err   = 1'b1;
                            nxt_state = serial_byte_pkg::ST_STOP;
                        end else begin
                            nxt_bit = 4'h0;
                            if (step_ff == serial_byte_pkg::STEP_ADDR && short_ff) begin
                                nxt_step  = serial_byte_pkg::STEP_LAST;
                                nxt_state = dir ? serial_byte_pkg::ST_RECV : serial_byte_pkg::ST_SEND;
                                nxt_shift = xfer_byte_ff;
                            end else if (step_ff == serial_byte_pkg::STEP_ADDR) begin
                                nxt_step  = serial_byte_pkg::STEP_INDEX;
                                nxt_shift = byte_offset_ff;
                            end else if (step_ff == serial_byte_pkg::STEP_INDEX) begin
                                nxt_step  = serial_byte_pkg::STEP_LAST;
                                nxt_state = dir ? serial_byte_pkg::ST_START : serial_byte_pkg::ST_SEND;
                                nxt_rep   = 1'b1;
                                nxt_shift = xfer_byte_ff;
                            end else begin
                                nxt_state = dir ? serial_byte_pkg::ST_RECV : serial_byte_pkg::ST_STOP;
                            end
                        end
                    end
                    serial_byte_pkg::ST_RECV: begin
                        if (bit_ff == serial_byte_pkg::LAST_DATA_BIT) begin
                            nxt_xfer_byte = shift_ff;
                        end
                        if (bit_ff != serial_byte_pkg::ACK_BIT_NUM) begin
                            nxt_bit = bit_ff + 4'h1;
                        end else begin
                            nxt_state = serial_byte_pkg::ST_STOP;
                        end
                    end
                    serial_byte_pkg::ST_STOP: nxt_state = serial_byte_pkg::ST_IDLE;
                    default: nxt_state = serial_byte_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Only the global reset clears these; no bus reset reaches them
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff       <= serial_byte_pkg::ST_IDLE;
            xfer_byte_ff   <= serial_byte_pkg::REG_RESET_VAL;
            byte_offset_ff <= serial_byte_pkg::REG_RESET_VAL;
            target_addr_ff <= serial_byte_pkg::REG_RESET_VAL;
            short_ff       <= 1'b0;
            fast_ff        <= 1'b0;
            err_ff         <= 1'b0;
            rdata_ff       <= serial_byte_pkg::REG_RESET_VAL;
            shift_ff       <= serial_byte_pkg::REG_RESET_VAL;
            bit_ff         <= 4'h0;
            ph_ff          <= 2'h0;
            step_ff        <= serial_byte_pkg::STEP_ADDR;
            rep_ff         <= 1'b0;
            nack_ff        <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            xfer_byte_ff   <= nxt_xfer_byte;
            byte_offset_ff <= nxt_byte_offset;
            target_addr_ff <= nxt_target_addr;
            short_ff       <= nxt_short;
            fast_ff        <= nxt_fast;
            err_ff         <= nxt_err;
            rdata_ff       <= nxt_rdata;
            shift_ff       <= nxt_shift;
            bit_ff         <= nxt_bit;
            ph_ff          <= nxt_ph;
            step_ff        <= nxt_step;
            rep_ff         <= nxt_rep;
            nack_ff        <= nxt_nack;
        end
    end

    // ************************************************************
    // Pin drive: open drain, only ever pulls low
    // ************************************************************
    always_comb begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        unique case (state_ff)
            serial_byte_pkg::ST_START: begin
                scl_low = (ph_ff == 2'h0 && rep_ff) || ph_ff == 2'h3;
                sda_low = ph_ff[1];
            end
            serial_byte_pkg::ST_SEND: begin
                scl_low = ph_ff == 2'h0 || ph_ff == 2'h3;
                sda_low = bit_ff != serial_byte_pkg::ACK_BIT_NUM && !shift_ff[7];
            end
            serial_byte_pkg::ST_RECV: scl_low = ph_ff == 2'h0 || ph_ff == 2'h3;
            serial_byte_pkg::ST_STOP: begin
                scl_low = ph_ff == 2'h0;
                sda_low = !ph_ff[1];
            end
            default: ;
        endcase
    end

    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe_o    = scl_low;
    assign sda_oe_o    = sda_low;
    assign reg_rdata_o = rdata_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence launch_s;
        reg_wr_i && reg_addr_i == serial_byte_pkg::TARGET_ADDR_OFS && !busy;
    endsequence

    busy_launch_a: assert property (launch_s |=> busy [*8])
        else $error("access did not start busy");
    err_sticky_a: assert property (err_ff && !(reg_wr_i && reg_addr_i == serial_byte_pkg::CTRL_STATUS_OFS)
        |=> err_ff)
        else $error("error flag lost without clear");
    data_write_a: assert property (reg_wr_i && reg_addr_i == serial_byte_pkg::XFER_BYTE_OFS && !busy
        |=> xfer_byte_ff == $past(reg_wdata_i))
        else $error("data register write lost");
    index_hold_a: assert property (!(reg_wr_i && reg_addr_i == serial_byte_pkg::BYTE_OFFSET_OFS)
        |=> $stable(byte_offset_ff))
        else $error("index changed without a write");
    dir_bit_a: assert property (state_ff == serial_byte_pkg::ST_SEND && step_ff == serial_byte_pkg::STEP_ADDR
        && bit_ff == serial_byte_pkg::LAST_DATA_BIT |-> sda_oe_o == !(short_ff && dir))
        else $error("wrong direction bit on bus");
    short_no_index_a: assert property (short_ff && state_ff == serial_byte_pkg::ST_SEND
        |-> step_ff != serial_byte_pkg::STEP_INDEX)
        else $error("index sent in short framing");
    recv_nack_a: assert property (state_ff == serial_byte_pkg::ST_RECV && bit_ff == serial_byte_pkg::ACK_BIT_NUM
        |-> !sda_oe_o)
        else $error("received byte was acknowledged");
    idle_release_a: assert property (!busy |-> !scl_oe_o && !sda_oe_o)
        else $error("bus driven while idle");

endmodule : serial_byte_master

`default_nettype wire

// ### pkg/serial_byte_pkg.sv
package serial_byte_pkg;

    // ************************************************************
    // Register offsets and fields
    // ************************************************************
    localparam logic [7:0] XFER_BYTE_OFS    = 8'hB0;
    localparam logic [7:0] BYTE_OFFSET_OFS  = 8'hB1;
    localparam logic [7:0] TARGET_ADDR_OFS  = 8'hB2;
    localparam logic [7:0] CTRL_STATUS_OFS  = 8'hB3;
    localparam logic [7:0] REG_RESET_VAL    = 8'h00;
    localparam int         SHORT_FRAME_BIT  = 7;
    localparam int         BUSY_BIT         = 5;
    localparam int         FAST_TEST_BIT    = 2;
    localparam int         REQ_ERR_BIT      = 1;

    // ************************************************************
    // Timing: one serial bit is four quarter phases
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned QUARTER_NORMAL_NS = 2500;
    localparam int unsigned QUARTER_TEST_NS   = 625;
    localparam int unsigned QUARTER_NORMAL_CYC =
        (QUARTER_NORMAL_NS / CLK_PERIOD_NS) > 0 ? QUARTER_NORMAL_NS / CLK_PERIOD_NS : 1;
    localparam int unsigned QUARTER_TEST_CYC =
        (QUARTER_TEST_NS / CLK_PERIOD_NS) > 0 ? QUARTER_TEST_NS / CLK_PERIOD_NS : 1;
    localparam logic [3:0]  ACK_BIT_NUM       = 4'h8;
    localparam logic [3:0]  LAST_DATA_BIT     = 4'h7;

    // ************************************************************
    // Sequencer states and frame steps
    // ************************************************************
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_SEND  = 5'h04,
        ST_RECV  = 5'h08,
        ST_STOP  = 5'h10
    } seq_state_t;

    localparam logic [1:0] STEP_ADDR  = 2'h0;
    localparam logic [1:0] STEP_INDEX = 2'h1;
    localparam logic [1:0] STEP_LAST  = 2'h2;

endpackage : serial_byte_pkg

// ### verilog/quarter_tick_div.sv
`timescale 1ns/1ns
`default_nettype none

module quarter_tick_div (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    // Rate select
    input  wire logic fast_clock_test_i,
    // Quarter-bit enable
    output logic      tick_o
);

    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic       tick_ff;
    logic       nxt_tick;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt  = cnt_ff - 8'h01;
        if (cnt_ff == 8'h00) begin
            nxt_tick = 1'b1;
            nxt_cnt  = fast_clock_test_i ? 8'(serial_byte_pkg::QUARTER_TEST_CYC - 1)
                                         : 8'(serial_byte_pkg::QUARTER_NORMAL_CYC - 1);
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    tick_spacing_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        tick_o |=> !tick_o [*8])
        else $error("quarter ticks too close together");

endmodule : quarter_tick_div

`default_nettype wire

// ### sim/two_wire_target.sv
`timescale 1ns/1ns
`default_nettype none

module two_wire_target #(
    parameter logic [6:0] OWN_ADDR = 7'h50
) (
    // Wire levels
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Data pull-down
    output logic      sda_oe_o
);
    logic [7:0] mem [256];
    logic [7:0] ptr;
    logic [7:0] last_addr;
    logic       master_nack;
    int         wr_count;
    realtime    rise_t;
    realtime    scl_per;

    // ************************************************************
    // Bit level helpers
    // ************************************************************
    always @(posedge scl_i) begin
        scl_per = $realtime - rise_t;
        rise_t = $realtime;
    end

    // Event 0 data bit, 1 repeated start, 2 stop
    task automatic rx_byte(output logic [7:0] v, output int ev);
        v = 8'h00;
        ev = 0;
        for (int i = 0; i < 8 && ev == 0; i++) begin
            @(posedge scl_i);
            v = {v[6:0], sda_i};
            @(negedge scl_i or sda_i);
            ev = (scl_i === 1'b0) ? 0 : ((sda_i === 1'b1) ? 2 : 1);
        end
    endtask : rx_byte

    task automatic ack_bit();
        sda_oe_o = 1'b1;
        @(posedge scl_i);
        @(negedge scl_i);
        sda_oe_o = 1'b0;
    endtask : ack_bit

    task automatic tx_byte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            sda_oe_o = ~d[i];
            @(posedge scl_i);
            @(negedge scl_i);
        end
        sda_oe_o = 1'b0;
    endtask : tx_byte

    // ************************************************************
    // Frame handling
    // ************************************************************
    initial begin : serve
        logic [7:0] v;
        int         ev;
        logic       live;
        sda_oe_o = 1'b0;
        ptr = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~i[7:0];
        end
        forever begin
            @(negedge sda_i iff scl_i === 1'b1);
            live = 1'b1;
            while (live) begin
                rx_byte(v, ev);
                live = (ev == 1);
                if (ev == 0) begin
                    last_addr = v;
                    // Foreign address is left unacknowledged
                    if (v[7:1] == OWN_ADDR && v[0]) begin
                        ack_bit();
                        tx_byte(mem[ptr]);
                        // Ninth bit of a read must be left high by the master
                        @(posedge scl_i);
                        master_nack = sda_i;
                    end else if (v[7:1] == OWN_ADDR) begin
                        ack_bit();
                        wr_count = 0;
                        rx_byte(v, ev);
                        while (ev == 0) begin
                            ack_bit();
                            if (wr_count == 0) begin
                                ptr = v;
                            end else begin
                                mem[ptr] = v;
                            end
                            wr_count++;
                            rx_byte(v, ev);
                        end
                        live = (ev == 1);
                    end
                end
            end
        end
    end
endmodule : two_wire_target

`default_nettype wire

// ### sim/serial_byte_master_tb.sv
`timescale 1ns/1ns
`default_nettype none

module serial_byte_master_tb;

    // ************************************************************
    // Signals
    // ************************************************************
    logic       ref_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       scl_out;
    logic       scl_oe;
    logic       sda_out;
    logic       sda_oe;
    logic       tgt_oe;
    // Pulled-up wires: a released pin reads high, a driven one shows its output
    wire logic  scl_w = scl_oe ? scl_out : 1'b1;
    wire logic  sda_w = (sda_oe ? sda_out : 1'b1) & ~tgt_oe;
    int         bad_count = 0;
    int         checked = 0;
    localparam logic [7:0] CSR = serial_byte_pkg::CTRL_STATUS_OFS;

    always #5 ref_clk = ~ref_clk;

    serial_byte_master i_dut (
        .ref_clk_i(ref_clk), .reset_n_i(reset_n), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .scl_i(scl_w), .scl_o(scl_out), .scl_oe_o(scl_oe),
        .sda_i(sda_w), .sda_o(sda_out), .sda_oe_o(sda_oe));

    two_wire_target i_target (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(tgt_oe));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8

    task automatic reg_wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge ref_clk);
        #1 reg_wr = 1'b0;
    endtask : reg_wr8

    task automatic reg_rd8(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1 {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge ref_clk);
        #1 reg_rd = 1'b0;
        d = reg_rdata;
    endtask : reg_rd8

    // Busy set one cycle after the launch, then polled under a bound
    task automatic run_xfer(input logic [7:0] ctrl, input logic [7:0] data,
                            input logic [7:0] idx, input logic [7:0] tgt, output logic [7:0] st);
        int n;
        reg_wr8(CSR, ctrl);
        reg_wr8(serial_byte_pkg::XFER_BYTE_OFS, data);
        reg_wr8(serial_byte_pkg::BYTE_OFFSET_OFS, idx);
        reg_wr8(serial_byte_pkg::TARGET_ADDR_OFS, tgt);
        reg_rd8(CSR, st);
        check8(st, ctrl | (8'h01 << serial_byte_pkg::BUSY_BIT));
        for (n = 0; n < 20000 && st[serial_byte_pkg::BUSY_BIT] !== 1'b0; n++) begin
            reg_rd8(CSR, st);
        end
        // A poll limit that runs out counts as a mismatch
        check8(st & (8'h01 << serial_byte_pkg::BUSY_BIT), 8'h00);
    endtask : run_xfer

    task automatic check_rate(input int quarter_cyc);
        real exp_ns;
        exp_ns = 4.0 * quarter_cyc * serial_byte_pkg::CLK_PERIOD_NS;
        check8({7'h00, i_target.scl_per > exp_ns - 100.0 && i_target.scl_per < exp_ns + 100.0}, 8'h01);
    endtask : check_rate

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_values();
        logic [7:0] v;
        for (int a = 0; a < 5; a++) begin
            reg_rd8(8'hB0 + a[7:0], v);
            check8(v, serial_byte_pkg::REG_RESET_VAL);
        end
    endtask : t_reset_values

    task automatic t_reg_rw();
        logic [7:0] v;
        reg_wr8(serial_byte_pkg::XFER_BYTE_OFS, 8'hA5);
        reg_wr8(serial_byte_pkg::BYTE_OFFSET_OFS, 8'h5A);
        reg_wr8(8'hB4, 8'hFF);
        reg_rd8(serial_byte_pkg::XFER_BYTE_OFS, v);
        check8(v, 8'hA5);
        reg_rd8(serial_byte_pkg::BYTE_OFFSET_OFS, v);
        check8(v, 8'h5A);
        reg_rd8(8'hB4, v);
        check8(v, 8'h00);
    endtask : t_reg_rw

    task automatic t_write_read();
        logic [7:0] st;
        logic [7:0] v;
        run_xfer(8'h04, 8'h5A, 8'h3C, 8'hA0, st);
        check8(st, 8'h04);
        check8(i_target.mem[8'h3C], 8'h5A);
        check8(i_target.last_addr, 8'hA0);
        check8(i_target.wr_count[7:0], 8'h02);
        check_rate(serial_byte_pkg::QUARTER_TEST_CYC);
        reg_rd8(serial_byte_pkg::TARGET_ADDR_OFS, v);
        check8(v, 8'hA0);
        run_xfer(8'h04, 8'h00, 8'h3C, 8'hA1, st);
        reg_rd8(serial_byte_pkg::XFER_BYTE_OFS, v);
        check8(v, 8'h5A);
        check8(i_target.last_addr, 8'hA1);
        check8({7'h00, i_target.master_nack}, 8'h01);
    endtask : t_write_read

    task automatic t_nack();
        logic [7:0] st;
        run_xfer(8'h00, 8'h11, 8'h22, 8'h44, st);
        check8(st, 8'h02);
        check_rate(serial_byte_pkg::QUARTER_NORMAL_CYC);
        reg_wr8(CSR, 8'h02);
        reg_rd8(CSR, st);
        check8(st, 8'h00);
    endtask : t_nack

    task automatic t_short();
        logic [7:0] st;
        logic [7:0] v;
        run_xfer(8'h84, 8'h77, 8'h3C, 8'hA0, st);
        check8(i_target.ptr, 8'h77);
        check8(i_target.wr_count[7:0], 8'h01);
        run_xfer(8'h84, 8'h00, 8'h3C, 8'hA1, st);
        reg_rd8(serial_byte_pkg::XFER_BYTE_OFS, v);
        check8(v, 8'h88);
    endtask : t_short

    task automatic t_mid_reset();
        reg_wr8(CSR, 8'h04);
        reg_wr8(serial_byte_pkg::TARGET_ADDR_OFS, 8'hA0);
        repeat (300) @(posedge ref_clk);
        #1 reset_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1 check8({6'h00, scl_oe, sda_oe}, 8'h00);
        check8(reg_rdata, serial_byte_pkg::REG_RESET_VAL);
        reset_n = 1'b1;
        t_reset_values();
    endtask : t_mid_reset

    // ************************************************************
    // Sequence and verdict
    // ************************************************************
    task automatic results();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    initial begin
        repeat (8) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        t_reset_values();
        t_reg_rw();
        t_write_read();
        t_nack();
        t_short();
        t_mid_reset();
        results();
    end

    initial begin
        // About twice the expected run, well inside the cycle budget
        #800000;
        bad_count++;
        results();
    end
endmodule : serial_byte_master_tb

`default_nettype wire
